// File: ptp_packet_buffers.sv
// timing-frame receive and transmit stores with their control registers on APB
// assumes the MAC receive path, transmit arbiter and host bus all run on SYS_CLK
// Function
// - receive store is 4K bytes in sixteen 256-byte slots, one frame each
// - received frame goes to write-pointer slot, then pointer advances
// - received frame fills its slot upward from the slot's lowest address
// - receive timestamp lands in the top four bytes of the frame's slot
// - receive slot n sits at 0x10000 + n*0x100, all bytes host readable
// - transmit store is 2K bytes in eight 256-byte slots, host read/write
// - seven transmit slots load default frame contents at start, still writable
// - first byte of a transmit slot gives the byte count to send
// - transmit frame is fetched starting at byte eight of its slot
// - transmit timestamp written to top four bytes of the slot just sent
// - transmit slot n at 0x11000 + n*0x100 with listed default frames
// - stores exist only when the bridging endpoint option is present
// - configuration registers decoded at 0x12000 to 0x127fc as listed
// - write-only send bits 7:0 request the arbiter and read as zero
// - pending bits 15:8 until sent; bits 18:16 give last sent slot
// - receive-clear moves write pointer to read pointer; 11:8 last filled slot
// - transmit and receive interrupts set per frame, cleared by control access
module ptp_packet_buffers #(
  parameter bit ENDPOINT_PRESENT = 1'b1
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             IRQ,
  input  wire logic        RX_DATA_VALID,
  input  wire logic [7:0]  RX_DATA,
  input  wire logic        RX_FRAME_END,
  input  wire logic        RX_FRAME_GOOD,
  input  wire logic [31:0] RX_TIMESTAMP,
  output logic             TX_REQUEST,
  input  wire logic        TX_GRANT,
  output logic             TX_DATA_VALID,
  output logic      [7:0]  TX_DATA,
  output logic             TX_LAST,
  input  wire logic        TX_DATA_READY,
  input  wire logic        TX_TS_VALID,
  input  wire logic [31:0] TX_TIMESTAMP,
  output logic      [19:0] CREDIT_DECREASE_RATE,
  output logic      [19:0] CREDIT_INCREASE_RATE
);
  typedef struct packed {
    ptp_buf_pkg::tx_state_t st;
    logic [8:0]             init_idx;
    logic [7:0]             pend;
    logic [2:0]             cur;
    logic [2:0]             tx_last;
    logic [7:0]             len;
    logic [7:0]             cnt;
    logic [7:0]             tx_byte;
    logic [3:0]             rx_wr;
    logic [3:0]             rx_rd;
    logic [3:0]             rx_last;
    logic [7:0]             rx_cnt;
    logic [19:0]            dec_rate;
    logic [19:0]            inc_rate;
    logic [1:0]             int_stat;
    logic [1:0]             int_mask;
    logic                   ack;
    logic                   slverr;
    logic [31:0]            prdata;
  } state_t;

  state_t      s_r;
  state_t      s_nxt;
  logic [31:0] rx_a_rdata;
  logic [9:0]  rx_b_addr;
  logic [3:0]  rx_b_we;
  logic [31:0] rx_b_wdata;
  logic [31:0] tx_a_rdata;
  logic [31:0] tx_b_rdata;
  logic [3:0]  tx_a_we;
  logic [8:0]  tx_b_addr;
  logic [3:0]  tx_b_we;
  logic [31:0] tx_b_wdata;
  logic [31:0] init_word;
  logic        in_rx;
  logic        in_tx;
  logic        in_cfg;
  logic        done;
  logic        wr_done;
  logic        rx_clear_req;
  logic        tx_set;
  logic        rx_set;
  logic        tx_clr;
  logic        rx_clr;
  logic [7:0]  tx_idx;
  logic [31:0] rd_val;

  function automatic logic in_window(input logic [31:0] a, input logic [31:0] base, input logic [31:0] bytes);
    in_window = (a >= base) && (a < base + bytes);
  endfunction

  function automatic logic [2:0] lowest_set(input logic [7:0] v);
    lowest_set = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        lowest_set = 3'(i);
      end
    end
  endfunction

  // stores vanish from the map when the endpoint option is left out
  assign in_rx   = ENDPOINT_PRESENT && in_window(PADDR, ptp_buf_pkg::RX_STORE_BASE, ptp_buf_pkg::RX_STORE_BYTES);
  assign in_tx   = ENDPOINT_PRESENT && in_window(PADDR, ptp_buf_pkg::TX_STORE_BASE, ptp_buf_pkg::TX_STORE_BYTES);
  assign in_cfg  = ENDPOINT_PRESENT && in_window(PADDR, ptp_buf_pkg::CFG_BASE, ptp_buf_pkg::CFG_BYTES);
  assign done    = PSEL && PENABLE && s_r.ack;
  assign wr_done = done && PWRITE;
  assign rx_clear_req = wr_done && PADDR == ptp_buf_pkg::ADDR_RX_CTRL && PWDATA[ptp_buf_pkg::RX_CLEAR_BIT];
  assign tx_set  = s_r.st == ptp_buf_pkg::TX_STAMP && TX_TS_VALID;
  assign rx_set  = RX_FRAME_END && RX_FRAME_GOOD;
  assign tx_clr  = done && PADDR == ptp_buf_pkg::ADDR_TX_CTRL;
  assign rx_clr  = done && PADDR == ptp_buf_pkg::ADDR_RX_CTRL;
  assign tx_idx  = s_r.cnt + ptp_buf_pkg::TX_DATA_START;
  // host writes to the transmit store; the receive store is read-only to the host
  assign tx_a_we = (wr_done && in_tx) ? PSTRB : 4'h0;

  // the store read issued at the setup cycle is ready in the first access cycle
  always_comb begin
    rd_val = 32'h0000_0000;
    if (in_rx) begin
      rd_val = rx_a_rdata;
    end else if (in_tx) begin
      rd_val = tx_a_rdata;
    end else if (in_cfg && PADDR == ptp_buf_pkg::ADDR_TX_CTRL) begin
      rd_val = (32'(s_r.tx_last) << ptp_buf_pkg::TX_LAST_LSB) | (32'(s_r.pend) << ptp_buf_pkg::TX_PEND_LSB);
    end else if (in_cfg && PADDR == ptp_buf_pkg::ADDR_RX_CTRL) begin
      rd_val = 32'(s_r.rx_last) << ptp_buf_pkg::RX_LAST_LSB;
    end else if (in_cfg && PADDR == ptp_buf_pkg::ADDR_DEC_RATE) begin
      rd_val = {12'h000, s_r.dec_rate};
    end else if (in_cfg && PADDR == ptp_buf_pkg::ADDR_INC_RATE) begin
      rd_val = {12'h000, s_r.inc_rate};
    end else if (in_cfg && PADDR == ptp_buf_pkg::ADDR_INT_STAT) begin
      rd_val = {30'h0000_0000, s_r.int_stat};
    end else if (in_cfg && PADDR == ptp_buf_pkg::ADDR_INT_MASK) begin
      rd_val = {30'h0000_0000, s_r.int_mask};
    end
  end

  always_comb begin
    s_nxt      = s_r;
    rx_b_addr  = {s_r.rx_wr, s_r.rx_cnt[7:2]};
    rx_b_we    = 4'h0;
    rx_b_wdata = {4{RX_DATA}};
    tx_b_addr  = {s_r.cur, 6'h00};
    tx_b_we    = 4'h0;
    tx_b_wdata = 32'h0000_0000;

    // bus slave: one wait state, then the transfer completes
    if (PSEL && PENABLE && !s_r.ack) begin
      s_nxt.ack    = 1'b1;
      s_nxt.prdata = rd_val;
      s_nxt.slverr = !(in_rx || in_tx || in_cfg);
    end
    if (done) begin
      s_nxt.ack = 1'b0;
    end
    if (wr_done && in_cfg) begin
      if (PADDR == ptp_buf_pkg::ADDR_DEC_RATE) begin
        s_nxt.dec_rate = PWDATA[19:0];
      end else if (PADDR == ptp_buf_pkg::ADDR_INC_RATE) begin
        s_nxt.inc_rate = PWDATA[19:0];
      end else if (PADDR == ptp_buf_pkg::ADDR_INT_MASK) begin
        s_nxt.int_mask = PWDATA[1:0];
      end else if (PADDR == ptp_buf_pkg::ADDR_INT_STAT) begin
        s_nxt.int_stat = s_r.int_stat & ~PWDATA[1:0];
      end
    end
    // a host read of a receive slot marks it as the read position
    if (done && !PWRITE && in_rx) begin
      s_nxt.rx_rd = PADDR[11:8];
    end

    // receive path
    if (RX_DATA_VALID && s_r.rx_cnt < ptp_buf_pkg::RX_MAX_LEN) begin
      rx_b_we      = 4'h1 << s_r.rx_cnt[1:0];
      s_nxt.rx_cnt = s_r.rx_cnt + 8'h01;
    end
    if (RX_FRAME_END) begin
      s_nxt.rx_cnt = 8'h00;
      if (RX_FRAME_GOOD) begin
        rx_b_addr     = {s_r.rx_wr, ptp_buf_pkg::STAMP_WORD};
        rx_b_we       = 4'hf;
        rx_b_wdata    = RX_TIMESTAMP;
        s_nxt.rx_last = s_r.rx_wr;
        s_nxt.rx_wr   = s_r.rx_wr + 4'h1;
      end
    end
    // clearing also abandons a frame that is part written
    if (rx_clear_req) begin
      s_nxt.rx_wr  = s_r.rx_rd;
      s_nxt.rx_cnt = 8'h00;
    end

    // transmit path
    case (s_r.st)
      ptp_buf_pkg::TX_INIT: begin
        tx_b_addr      = s_r.init_idx;
        tx_b_we        = 4'hf;
        tx_b_wdata     = init_word;
        s_nxt.init_idx = s_r.init_idx + 9'h001;
        if (s_r.init_idx == ptp_buf_pkg::TX_INIT_LAST) begin
          s_nxt.st = ptp_buf_pkg::TX_IDLE;
        end
      end
      ptp_buf_pkg::TX_IDLE: begin
        if (TX_GRANT && s_r.pend != 8'h00) begin
          s_nxt.cur = lowest_set(s_r.pend);
          s_nxt.st  = ptp_buf_pkg::TX_LEN;
        end
      end
      ptp_buf_pkg::TX_LEN: begin
        s_nxt.st = ptp_buf_pkg::TX_LENW;
      end
      ptp_buf_pkg::TX_LENW: begin
        // the length byte bounds the send; it is never put on the wire
        s_nxt.len = (tx_b_rdata[7:0] > ptp_buf_pkg::TX_MAX_LEN) ? ptp_buf_pkg::TX_MAX_LEN : tx_b_rdata[7:0];
        s_nxt.cnt = 8'h00;
        if (tx_b_rdata[7:0] == 8'h00) begin
          s_nxt.pend[s_r.cur] = 1'b0;
          s_nxt.st            = ptp_buf_pkg::TX_IDLE;
        end else begin
          s_nxt.st = ptp_buf_pkg::TX_FETCH;
        end
      end
      ptp_buf_pkg::TX_FETCH: begin
        tx_b_addr = {s_r.cur, tx_idx[7:2]};
        s_nxt.st  = ptp_buf_pkg::TX_LOAD;
      end
      ptp_buf_pkg::TX_LOAD: begin
        s_nxt.tx_byte = tx_b_rdata[8*tx_idx[1:0] +: 8];
        s_nxt.st      = ptp_buf_pkg::TX_SEND;
      end
      ptp_buf_pkg::TX_SEND: begin
        if (TX_DATA_READY) begin
          s_nxt.cnt = s_r.cnt + 8'h01;
          s_nxt.st  = (s_r.cnt + 8'h01 == s_r.len) ? ptp_buf_pkg::TX_STAMP : ptp_buf_pkg::TX_FETCH;
        end
      end
      ptp_buf_pkg::TX_STAMP: begin
        if (TX_TS_VALID) begin
          tx_b_addr           = {s_r.cur, ptp_buf_pkg::STAMP_WORD};
          tx_b_we             = 4'hf;
          tx_b_wdata          = TX_TIMESTAMP;
          s_nxt.pend[s_r.cur] = 1'b0;
          s_nxt.tx_last       = s_r.cur;
          s_nxt.st            = ptp_buf_pkg::TX_IDLE;
        end
      end
      default: s_nxt.st = ptp_buf_pkg::TX_IDLE;
    endcase
    // a new request wins over the clear of the same slot
    if (wr_done && PADDR == ptp_buf_pkg::ADDR_TX_CTRL) begin
      s_nxt.pend = s_nxt.pend | PWDATA[7:0];
    end

    // interrupt status: a set in the clearing cycle is kept
    if (tx_clr) begin
      s_nxt.int_stat[ptp_buf_pkg::INT_TX_BIT] = 1'b0;
    end
    if (rx_clr) begin
      s_nxt.int_stat[ptp_buf_pkg::INT_RX_BIT] = 1'b0;
    end
    if (tx_set) begin
      s_nxt.int_stat[ptp_buf_pkg::INT_TX_BIT] = 1'b1;
    end
    if (rx_set) begin
      s_nxt.int_stat[ptp_buf_pkg::INT_RX_BIT] = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      s_r          <= '0;
      s_r.st       <= ptp_buf_pkg::TX_INIT;
      s_r.dec_rate <= ptp_buf_pkg::DEC_RATE_RST;
      s_r.inc_rate <= ptp_buf_pkg::INC_RATE_RST;
      s_r.int_mask <= ptp_buf_pkg::INT_MASK_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ptp_word_ram #(.WORDS(ptp_buf_pkg::RX_WORDS), .AW(10)) rx_store (
    .clk     (SYS_CLK),
    .a_addr  (PADDR[11:2]),
    .a_we    (4'h0),
    .a_wdata (32'h0000_0000),
    .a_rdata (rx_a_rdata),
    .b_addr  (rx_b_addr),
    .b_we    (rx_b_we),
    .b_wdata (rx_b_wdata),
    .b_rdata ()
  );

  ptp_word_ram #(.WORDS(ptp_buf_pkg::TX_WORDS), .AW(9)) tx_store (
    .clk     (SYS_CLK),
    .a_addr  (PADDR[10:2]),
    .a_we    (tx_a_we),
    .a_wdata (PWDATA),
    .a_rdata (tx_a_rdata),
    .b_addr  (tx_b_addr),
    .b_we    (tx_b_we),
    .b_wdata (tx_b_wdata),
    .b_rdata (tx_b_rdata)
  );

  ptp_default_frames defaults (
    .word_idx (s_r.init_idx),
    .word     (init_word)
  );

  assign PRDATA               = s_r.prdata;
  assign PREADY               = s_r.ack;
  assign PSLVERR              = s_r.ack && s_r.slverr;
  assign IRQ                  = |(s_r.int_stat & s_r.int_mask);
  assign TX_REQUEST           = s_r.st == ptp_buf_pkg::TX_IDLE && s_r.pend != 8'h00;
  assign TX_DATA_VALID        = s_r.st == ptp_buf_pkg::TX_SEND;
  assign TX_DATA              = s_r.tx_byte;
  assign TX_LAST              = TX_DATA_VALID && (s_r.cnt + 8'h01 == s_r.len);
  assign CREDIT_DECREASE_RATE = s_r.dec_rate;
  assign CREDIT_INCREASE_RATE = s_r.inc_rate;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  sequence s_good_end;
    RX_FRAME_END && RX_FRAME_GOOD;
  endsequence
  sequence s_tx_stamp;
    s_r.st == ptp_buf_pkg::TX_STAMP && TX_TS_VALID;
  endsequence
  sequence s_last_taken;
    s_r.st == ptp_buf_pkg::TX_SEND && TX_DATA_READY && TX_LAST;
  endsequence
  sequence s_setup_then_access;
    (PSEL && !PENABLE) ##1 (PSEL && PENABLE);
  endsequence

  a_rx_slot_advance: assert property (s_good_end |=> s_r.rx_last == $past(s_r.rx_wr))
    else $error("receive last slot does not match the filled slot");
  a_rx_ptr_wrap: assert property (s_good_end ##0 (s_r.rx_wr == 4'hf && !rx_clear_req) |=> s_r.rx_wr == 4'h0)
    else $error("receive pointer did not wrap to slot zero");
  a_rx_stamp_top: assert property (s_good_end |-> rx_b_we == 4'hf && rx_b_addr[5:0] == 6'h3f && rx_b_wdata == RX_TIMESTAMP)
    else $error("receive timestamp not written to the slot top word");
  a_rx_clear_ptr: assert property (rx_clear_req |=> s_r.rx_wr == $past(s_r.rx_rd))
    else $error("receive clear did not move the write pointer");
  a_send_bits_zero: assert property ((done && !PWRITE && PADDR == ptp_buf_pkg::ADDR_TX_CTRL) |-> PRDATA[7:0] == 8'h00)
    else $error("send request bits read back nonzero");
  a_pend_on_request: assert property ((wr_done && PADDR == ptp_buf_pkg::ADDR_TX_CTRL) |=> (s_r.pend & $past(PWDATA[7:0])) == $past(PWDATA[7:0]))
    else $error("pending flag not set by a send request");
  a_tx_stamp_done: assert property (s_tx_stamp |-> tx_b_we == 4'hf && tx_b_addr[5:0] == 6'h3f ##1 s_r.tx_last == $past(s_r.cur) && s_r.int_stat[0] && s_r.st == ptp_buf_pkg::TX_IDLE)
    else $error("transmit completion did not stamp, report and interrupt");
  a_tx_len_bound: assert property (s_last_taken |=> s_r.st == ptp_buf_pkg::TX_STAMP && s_r.cnt == s_r.len)
    else $error("transmit did not stop at the length byte count");
  a_tx_first_word: assert property ((s_r.st == ptp_buf_pkg::TX_FETCH && s_r.cnt == 8'h00) |-> tx_b_addr[5:0] == 6'h02 ##2 s_r.st == ptp_buf_pkg::TX_SEND)
    else $error("transmit did not start at byte eight of the slot");
  a_tx_int_clear: assert property ((tx_clr && !tx_set) |=> !s_r.int_stat[0])
    else $error("transmit interrupt not cleared by control register access");
  a_apb_one_wait: assert property (s_setup_then_access |-> !PREADY ##1 PREADY)
    else $error("bus answer not after exactly one wait state");
endmodule

// File: ptp_buf_pkg.sv
// constants, address map and types shared by the timing-frame buffer block
// assumes a 32-bit byte-addressed host bus and a single 100 MHz clock
package ptp_buf_pkg;
  // host address map (byte addresses)
  localparam logic [31:0] RX_STORE_BASE  = 32'h0001_0000;
  localparam logic [31:0] RX_STORE_BYTES = 32'h0000_1000;
  localparam logic [31:0] TX_STORE_BASE  = 32'h0001_1000;
  localparam logic [31:0] TX_STORE_BYTES = 32'h0000_0800;
  localparam logic [31:0] CFG_BASE       = 32'h0001_2000;
  localparam logic [31:0] CFG_BYTES      = 32'h0000_0800;
  localparam logic [31:0] ADDR_TX_CTRL   = 32'h0001_2000;
  localparam logic [31:0] ADDR_RX_CTRL   = 32'h0001_2004;
  localparam logic [31:0] ADDR_RESERVED  = 32'h0001_2008;
  localparam logic [31:0] ADDR_DEC_RATE  = 32'h0001_200c;
  localparam logic [31:0] ADDR_INC_RATE  = 32'h0001_2010;
  localparam logic [31:0] ADDR_INT_STAT  = 32'h0001_2018;
  localparam logic [31:0] ADDR_INT_MASK  = 32'h0001_201c;
  // store geometry
  localparam int          RX_WORDS       = 1024;
  localparam int          TX_WORDS       = 512;
  localparam logic [5:0]  STAMP_WORD     = 6'h3f;
  localparam logic [7:0]  TX_DATA_START  = 8'h08;
  localparam logic [7:0]  TX_MAX_LEN     = 8'hf4;
  localparam logic [7:0]  RX_MAX_LEN     = 8'hfc;
  localparam logic [8:0]  TX_INIT_LAST   = 9'h1ff;
  // register fields
  localparam int          TX_PEND_LSB    = 8;
  localparam int          TX_LAST_LSB    = 16;
  localparam int          RX_CLEAR_BIT   = 0;
  localparam int          RX_LAST_LSB    = 8;
  localparam int          INT_TX_BIT     = 0;
  localparam int          INT_RX_BIT     = 1;
  // reset values
  localparam logic [19:0] DEC_RATE_RST   = 20'h00800;
  localparam logic [19:0] INC_RATE_RST   = 20'h01800;
  localparam logic [1:0]  INT_MASK_RST   = 2'h0;
  // default frame contents
  localparam logic [31:0] PTP_DA_LO      = 32'h00c2_8001;
  localparam logic [31:0] PTP_DA_HI_SA   = 32'h0000_0e00;
  localparam logic [15:0] PTP_ETHERTYPE  = 16'hf788;
  localparam logic [7:0]  PTP_VERSION    = 8'h02;
  localparam logic [7:0]  ETH_HDR_LEN    = 8'h0e;
  localparam logic [2:0]  DEFAULT_SLOTS  = 3'h7;
  localparam logic [7:0]  MSG_TYPE [7]   = '{8'h00, 8'h08, 8'h02, 8'h03, 8'h0a, 8'h0b, 8'h0c};
  localparam logic [7:0]  MSG_LEN  [7]   = '{8'h2c, 8'h2c, 8'h36, 8'h36, 8'h36, 8'h40, 8'h2c};

  typedef enum logic [2:0] {TX_INIT, TX_IDLE, TX_LEN, TX_LENW, TX_FETCH, TX_LOAD, TX_SEND, TX_STAMP} tx_state_t;
endpackage

// File: ptp_word_ram.sv
// two-port word memory with byte lanes and registered read data
// assumes both ports on one clock; on a same-word write collision port b wins
module ptp_word_ram #(
  parameter int WORDS = 1024,
  parameter int AW    = 10
) (
  input  wire logic          clk,
  input  wire logic [AW-1:0] a_addr,
  input  wire logic [3:0]    a_we,
  input  wire logic [31:0]   a_wdata,
  output logic      [31:0]   a_rdata,
  input  wire logic [AW-1:0] b_addr,
  input  wire logic [3:0]    b_we,
  input  wire logic [31:0]   b_wdata,
  output logic      [31:0]   b_rdata
);
  logic [31:0] mem [WORDS];

  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (a_we[i]) begin
        mem[a_addr][8*i +: 8] <= a_wdata[8*i +: 8];
      end
      if (b_we[i]) begin
        mem[b_addr][8*i +: 8] <= b_wdata[8*i +: 8];
      end
    end
    a_rdata <= mem[a_addr];
    b_rdata <= mem[b_addr];
  end
endmodule

// File: ptp_default_frames.sv
// power-up contents of the transmit store, one word per transmit-store word index
// assumes little-endian byte lanes: byte offset 0 of a word sits in bits 7:0
module ptp_default_frames (
  input  wire logic [8:0]  word_idx,
  output logic      [31:0] word
);
  logic [2:0] slot;
  logic [5:0] w;
  logic [7:0] mlen;

  always_comb begin
    slot = word_idx[8:6];
    w    = word_idx[5:0];
    word = 32'h0000_0000;
    mlen = 8'h00;
    if (slot < ptp_buf_pkg::DEFAULT_SLOTS) begin
      mlen = ptp_buf_pkg::MSG_LEN[slot];
      case (w)
        6'h00: word = {24'h00_0000, 8'(ptp_buf_pkg::ETH_HDR_LEN + mlen)};
        6'h02: word = ptp_buf_pkg::PTP_DA_LO;
        6'h03: word = ptp_buf_pkg::PTP_DA_HI_SA;
        6'h05: word = {ptp_buf_pkg::PTP_VERSION, ptp_buf_pkg::MSG_TYPE[slot], ptp_buf_pkg::PTP_ETHERTYPE};
        6'h06: word = {16'h0000, mlen, 8'h00};
        default: word = 32'h0000_0000;
      endcase
    end
  end
endmodule

// File: ptp_mac_model.sv
// partner model of the mac side: receive byte source, transmit sink and arbiter
// assumes send_frame is called just after a rising edge of clk
module ptp_mac_model #(
  parameter logic [31:0] TX_STAMP = 32'h5a3c_0f11
) (
  input  wire logic        clk,
  input  wire logic        grant_enable,
  output logic             rx_valid,
  output logic      [7:0]  rx_data,
  output logic             rx_end,
  output logic      [31:0] rx_stamp,
  input  wire logic        tx_request,
  output logic             tx_grant,
  input  wire logic        tx_valid,
  input  wire logic        tx_last,
  output logic             tx_ready,
  output logic             tx_stamp_valid,
  output logic      [31:0] tx_stamp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] pace_r;
  initial begin
    pace_r = 2'h0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_end = 1'b0;
    rx_stamp = 32'h0;
    tx_grant = 1'b0;
    tx_ready = 1'b0;
    tx_stamp_valid = 1'b0;
    tx_stamp = ~TX_STAMP;
  end
  // acceptance is off two cycles then on two, so each byte waits one cycle before it is taken
  always @(posedge clk) begin
    pace_r <= pace_r + 2'h1;
    tx_ready <= pace_r[1];
    tx_grant <= grant_enable && tx_request && !tx_grant;
    tx_stamp_valid <= tx_valid && tx_ready && tx_last;
    tx_stamp <= (tx_valid && tx_ready && tx_last) ? TX_STAMP : ~TX_STAMP;
  end
  // released lines carry the inverse so stale values never look valid
  task automatic send_frame(input int n, input logic [63:0] b, input logic [31:0] ts);
    for (int i = 0; i < n; i++) begin
      rx_valid <= 1'b1;
      rx_data <= b[8*i+:8];
      @(posedge clk);
    end
    rx_valid <= 1'b0;
    rx_data <= ~b[8*n-8+:8];
    rx_end <= 1'b1;
    rx_stamp <= ts;
    @(posedge clk);
    rx_end <= 1'b0;
    rx_stamp <= ~ts;
    @(posedge clk);
  endtask
endmodule

// File: ptp_packet_buffers_tb.sv
// self-checking bench: apb host, mac partner, read and transmit scoreboards
// assumes ptp_buf_pkg and ptp_mac_model are compiled first
module ptp_packet_buffers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] TXS = 32'h5a3c_0f11;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq, gnt_en;
  logic        rx_valid, rx_end, tx_request, tx_grant, tx_valid, tx_last, tx_ready, tx_ts_valid;
  logic [31:0] paddr, pwdata, prdata, rx_stamp, tx_stamp, seed, w1, w2;
  logic [7:0]  rx_data, tx_data;
  logic [19:0] dec_rate, inc_rate;
  logic [63:0] d;
  logic [32:0] exp_rd[$];
  logic [8:0]  exp_tx[$];
  int          n_fail, checks_done;
  ptp_packet_buffers i_ptp_packet_buffers (.SYS_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq), .RX_DATA_VALID(rx_valid), .RX_DATA(rx_data), .RX_FRAME_END(rx_end),
    .RX_FRAME_GOOD(1'b1), .RX_TIMESTAMP(rx_stamp), .TX_REQUEST(tx_request), .TX_GRANT(tx_grant),
    .TX_DATA_VALID(tx_valid), .TX_DATA(tx_data), .TX_LAST(tx_last), .TX_DATA_READY(tx_ready),
    .TX_TS_VALID(tx_ts_valid), .TX_TIMESTAMP(tx_stamp), .CREDIT_DECREASE_RATE(dec_rate),
    .CREDIT_INCREASE_RATE(inc_rate));
  ptp_mac_model #(.TX_STAMP(TXS)) i_ptp_mac_model (.clk(clk), .grant_enable(gnt_en), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_end(rx_end), .rx_stamp(rx_stamp), .tx_request(tx_request), .tx_grant(tx_grant),
    .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .tx_stamp_valid(tx_ts_valid),
    .tx_stamp(tx_stamp));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] want);
    checks_done++;
    if (seen !== want) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] v);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [31:0] a, input logic [32:0] want);
    exp_rd.push_back(want);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // results are compared where they appear, against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite)
      chk("read", {pslverr, prdata}, exp_rd.pop_front());
    if (tx_valid && tx_ready)
      chk("tx byte", {tx_last, tx_data}, exp_tx.pop_front());
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    seed = 32'h000eeb61;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    gnt_en = 1'b0;
    n_fail = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // defaults are still being copied for 512 cycles after release
    repeat (520) @(posedge clk);
    chk("dec rate", 33'(dec_rate), 33'h800);
    rd(ptp_buf_pkg::ADDR_DEC_RATE, 33'h800);
    w1 = xs();
    apb(1'b1, ptp_buf_pkg::ADDR_INC_RATE, w1);
    rd(ptp_buf_pkg::ADDR_INC_RATE, {13'h0, w1[19:0]});
    chk("inc rate", 33'(inc_rate), {13'h0, w1[19:0]});
    apb(1'b1, ptp_buf_pkg::ADDR_RESERVED, w1);
    rd(ptp_buf_pkg::ADDR_RESERVED, 33'h0);
    rd(32'h0001_3000, {1'b1, 32'h0});
    apb(1'b1, ptp_buf_pkg::ADDR_INT_MASK, 32'h3);
    for (int s = 0; s < 8; s++)
      rd(ptp_buf_pkg::TX_STORE_BASE + 32'(s) * 32'h100 + 32'h8, {1'b0, s < 7 ? ptp_buf_pkg::PTP_DA_LO : 32'h0});
    $display("test registers and defaults done");
    d = {xs(), xs()};
    w2 = xs();
    i_ptp_mac_model.send_frame(8, d, w2);
    rd(ptp_buf_pkg::RX_STORE_BASE, {1'b0, d[31:0]});
    rd(ptp_buf_pkg::RX_STORE_BASE + 32'h4, {1'b0, d[63:32]});
    rd(ptp_buf_pkg::RX_STORE_BASE + 32'hfc, {1'b0, w2});
    chk("irq", 33'(irq), 33'h1);
    rd(ptp_buf_pkg::ADDR_INT_STAT, 33'h2);
    rd(ptp_buf_pkg::ADDR_RX_CTRL, 33'h0);
    chk("irq", 33'(irq), 33'h0);
    for (int i = 1; i <= 16; i++) begin
      d = {32'h0, xs()};
      i_ptp_mac_model.send_frame(4, d, xs());
    end
    rd(ptp_buf_pkg::ADDR_RX_CTRL, 33'h0);
    rd(ptp_buf_pkg::RX_STORE_BASE, {1'b0, d[31:0]});
    apb(1'b1, ptp_buf_pkg::ADDR_RX_CTRL, 32'h1);
    i_ptp_mac_model.send_frame(4, d, xs());
    rd(ptp_buf_pkg::ADDR_RX_CTRL, 33'h0);
    $display("test receive done");
    d = {xs(), xs()};
    apb(1'b1, ptp_buf_pkg::TX_STORE_BASE + 32'h700, 32'h5);
    apb(1'b1, ptp_buf_pkg::TX_STORE_BASE + 32'h708, d[31:0]);
    apb(1'b1, ptp_buf_pkg::TX_STORE_BASE + 32'h70c, d[63:32]);
    for (int i = 0; i < 5; i++)
      exp_tx.push_back({i == 4, d[8*i+:8]});
    apb(1'b1, ptp_buf_pkg::ADDR_TX_CTRL, 32'h80);
    rd(ptp_buf_pkg::ADDR_TX_CTRL, 33'h8000);
    chk("tx request", 33'(tx_request), 33'h1);
    gnt_en <= 1'b1;
    for (int i = 0; i < 400 && irq !== 1'b1; i++)
      @(posedge clk);
    chk("tx left", 33'(exp_tx.size()), 33'h0);
    chk("tx irq", 33'(irq), 33'h1);
    chk("tx request", 33'(tx_request), 33'h0);
    rd(ptp_buf_pkg::ADDR_TX_CTRL, 33'h70000);
    chk("irq", 33'(irq), 33'h0);
    rd(ptp_buf_pkg::TX_STORE_BASE + 32'h7fc, {1'b0, TXS});
    // a zero length byte must send nothing, stamp nothing and still retire the request
    apb(1'b1, ptp_buf_pkg::TX_STORE_BASE + 32'h700, 32'h0);
    apb(1'b1, ptp_buf_pkg::ADDR_TX_CTRL, 32'h80);
    repeat (10) @(posedge clk);
    rd(ptp_buf_pkg::ADDR_TX_CTRL, 33'h70000);
    chk("len0 irq", 33'(irq), 33'h0);
    $display("test transmit done");
    tally_and_finish();
  end
endmodule
